/* File: rtl/sbc_side_channels.sv */
/*
 * Command/indication and monitor side channels on the 8 kHz frame bus.
 * Assumes link clock, frame sync and receive data arrive from another
 * clock domain, and a single-cycle register port from the host.
 */
// The placing of the registers and the strobed register port were chosen for this implementation.
// How it works
// (RQ1) Four-bit code channel in every mode
// (RQ2) Accept new code after two equal frames
// (RQ3) Send tx code every frame
// (RQ4) Code channel gated by bus access grant
// (RQ5) Six-bit second channel only newer terminal
// (RQ6) Six-bit change flags immediately
// (RQ7) Software avoids bytes with upper nibble ones
// (RQ8) Far end clears handshake, answers next frame
// (RQ9) Older variant latches byte after handshake zero
// (RQ10) Two monitor channels only in terminal mode
// (RQ11) Resend monitor byte each frame until acked
// (RQ12) Control bit zero forces handshake idle
// (RQ13) Per-channel status flags and busy flag
// (RQ14) Transmit control enables active-low handshake
// (RQ15) Falling transmit handshake stores byte, flags
// (RQ16) Receive control on acknowledges first byte
// (RQ17) New byte: one inactive frame, then active
// (RQ18) Receive register read: one inactive frame
// (RQ19) No timeout on any handshake step
// (RQ20) Two inactive transmit frames end reception
// (RQ21) Clearing receive control ends busy flag; code ends it on cleared transmit control plus two idle MR frames
// (RQ22) Two inactive receive frames abort transfer
// (RQ23) Software checks busy zero before starting
`timescale 1ns/1ns
`default_nettype none
module sbc_side_channels
    import sbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic frame_sync,
    input wire logic link_rx,
    output logic link_tx,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    // ****************************************************************
    // Link sampling
    // ****************************************************************
    logic [2:0] sync1_reg, sync2_reg;
    logic lclk_d_reg;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            lclk_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {link_rx, frame_sync, link_clk};
            sync2_reg <= sync1_reg;
            lclk_d_reg <= sync2_reg[0];
        end
    end
    logic lrise;
    assign lrise = sync2_reg[0] && !lclk_d_reg;

    logic [4:0] bit_cnt_reg;
    logic [31:0] rx_sr_reg, tx_sr_reg;
    logic frame_done_reg;
    sbc_frame_t rx_frame, tx_frame;
    logic [31:0] tx_word;
    assign rx_frame = sbc_frame_t'(rx_sr_reg);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bit_cnt_reg <= 5'h0;
            rx_sr_reg <= 32'hFFFF_FFFF;
            tx_sr_reg <= 32'hFFFF_FFFF;
            link_tx <= 1'b1;
            frame_done_reg <= 1'b0;
        end else begin
            frame_done_reg <= 1'b0;
            if (lrise) begin
                rx_sr_reg <= {sync2_reg[2], rx_sr_reg[31:1]};
                if (sync2_reg[1]) begin
                    bit_cnt_reg <= 5'h1;
                    link_tx <= tx_word[0];
                    tx_sr_reg <= {1'b1, tx_word[31:1]};
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h1;
                    link_tx <= tx_sr_reg[0];
                    tx_sr_reg <= {1'b1, tx_sr_reg[31:1]};
                    frame_done_reg <= (bit_cnt_reg == FRAME_LAST);
                end
            end
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    logic [3:0] cmd_ind_rx_reg0_reg, cmd_ind_tx_reg0_reg, ci0_prev_reg;
    logic [5:0] cmd_ind_rx_reg1_reg, cmd_ind_tx_reg1_reg;
    logic [7:0] mor_reg [2];
    logic [7:0] mox_reg [2];
    logic [3:0] hsctl_reg;
    logic [7:0] hsstat_reg;
    logic [2:0] evt_reg;
    logic [1:0] mode_reg;
    logic [1:0] mac_reg;
    logic grant_reg;
    logic prev_e_reg;
    logic newer, term;
    logic [1:0] ch_en, rx_handshake_ctrl, tx_handshake_ctrl;
    assign newer = mode_reg[MODE_NEW];
    assign term = mode_reg[MODE_TERM];
    assign ch_en = {newer && term, newer}; // RQ10
    assign rx_handshake_ctrl = {hsctl_reg[2], hsctl_reg[0]};
    assign tx_handshake_ctrl = {hsctl_reg[3], hsctl_reg[1]};

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r, input logic s);
        hit = s && (a == r);
    endfunction

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_ind_tx_reg0_reg <= CI0_RESET;
            cmd_ind_tx_reg1_reg <= CI1_RESET;
            mox_reg[0] <= MON_RESET;
            mox_reg[1] <= MON_RESET;
            hsctl_reg <= 4'h0;
            mode_reg <= 2'h0;
        end else if (reg_wr) begin
            if (hit(reg_addr, REG_CI_TX0, 1'b1)) cmd_ind_tx_reg0_reg <= reg_wdata[3:0];
            if (hit(reg_addr, REG_CI_TX1, 1'b1)) cmd_ind_tx_reg1_reg <= reg_wdata[5:0];
            if (hit(reg_addr, REG_MON_TX0, 1'b1)) mox_reg[0] <= reg_wdata; // RQ7
            if (hit(reg_addr, REG_MON_TX1, 1'b1)) mox_reg[1] <= reg_wdata;
            if (hit(reg_addr, REG_HS_CTRL, 1'b1)) hsctl_reg <= reg_wdata[3:0];
            if (hit(reg_addr, REG_MODE, 1'b1)) mode_reg <= reg_wdata[1:0];
        end
    end

    // Handshake status and event register reads clear their flags; a set in the same cycle survives.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= BYTE_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CI_RX0: reg_rdata <= {4'h0, cmd_ind_rx_reg0_reg};
                REG_CI_TX0: reg_rdata <= {4'h0, cmd_ind_tx_reg0_reg};
                REG_CI_RX1: reg_rdata <= {2'h0, cmd_ind_rx_reg1_reg};
                REG_CI_TX1: reg_rdata <= {2'h0, cmd_ind_tx_reg1_reg};
                REG_MON_RX0: reg_rdata <= mor_reg[0];
                REG_MON_TX0: reg_rdata <= mox_reg[0];
                REG_MON_RX1: reg_rdata <= mor_reg[1];
                REG_MON_TX1: reg_rdata <= mox_reg[1];
                REG_HS_CTRL: reg_rdata <= {4'h0, hsctl_reg};
                REG_HS_STAT: reg_rdata <= hsstat_reg; // RQ13
                REG_GEN_STAT: reg_rdata <= {6'h00, mac_reg}; // RQ13
                REG_EXT_IRQ: reg_rdata <= {5'h00, evt_reg};
                REG_MODE: reg_rdata <= {6'h00, mode_reg};
                default: reg_rdata <= BYTE_ZERO;
            endcase
        end else begin
            reg_rdata <= BYTE_ZERO;
        end
    end

    // ****************************************************************
    // Command/indication channels
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_ind_rx_reg0_reg <= CI0_RESET;
            ci0_prev_reg <= CI0_RESET;
            cmd_ind_rx_reg1_reg <= CI1_RESET;
            evt_reg <= 3'h0;
            grant_reg <= 1'b1;
        end else begin
            if (hit(reg_addr, REG_EXT_IRQ, reg_rd)) evt_reg <= 3'h0;
            if (frame_done_reg) begin
                ci0_prev_reg <= rx_frame.ci0;
                grant_reg <= rx_frame.access; // RQ4
                if (rx_frame.ci0 == ci0_prev_reg && rx_frame.ci0 != cmd_ind_rx_reg0_reg) begin
                    cmd_ind_rx_reg0_reg <= rx_frame.ci0; // RQ1 RQ2
                    evt_reg[EV_CI0] <= 1'b1; // RQ2
                end
                if (ch_en[1] && rx_frame.ci1 != cmd_ind_rx_reg1_reg) begin
                    cmd_ind_rx_reg1_reg <= rx_frame.ci1; // RQ5
                    evt_reg[EV_CI1] <= 1'b1; // RQ6
                end
                if (!newer && !prev_e_reg) evt_reg[EV_MON] <= 1'b1; // RQ9
            end
        end
    end

    // ****************************************************************
    // Monitor channels
    // ****************************************************************
    // All steps wait on frames or software only; nothing times out.
    logic [1:0] prev_mx_reg, prev_mr_reg, mx_out_reg, mr_out_reg;
    logic [1:0] tx_new_reg, ack_req_reg, byte_new_reg, rx_act_reg, mr_seen_reg;
    logic [1:0] rmx, rmr;
    logic [7:0] rmon [2];
    assign rmx = {rx_frame.mx1, rx_frame.mx0};
    assign rmr = {rx_frame.mr1, rx_frame.mr0};
    assign rmon[0] = rx_frame.mon0;
    assign rmon[1] = rx_frame.mon1;

    always_ff @(posedge clk) begin // RQ19
        if (!rstn) begin
            prev_mx_reg <= 2'h3;
            prev_mr_reg <= 2'h3;
            mx_out_reg <= 2'h3;
            mr_out_reg <= 2'h3;
            tx_new_reg <= 2'h0;
            ack_req_reg <= 2'h0;
            byte_new_reg <= 2'h0;
            rx_act_reg <= 2'h0;
            mr_seen_reg <= 2'h0;
            mac_reg <= 2'h0;
            hsstat_reg <= BYTE_ZERO;
            prev_e_reg <= 1'b1;
            mor_reg[0] <= MON_RESET;
            mor_reg[1] <= MON_RESET;
        end else begin
            if (hit(reg_addr, REG_HS_STAT, reg_rd)) hsstat_reg <= BYTE_ZERO;
            if (frame_done_reg) prev_e_reg <= newer ? 1'b1 : rx_frame.mx0;
            if (frame_done_reg && !newer && !prev_e_reg) mor_reg[0] <= rx_frame.mon0; // RQ9
            for (int c = 0; c < 2; c++) begin
                if (hit(reg_addr, (c == 0) ? REG_MON_TX0 : REG_MON_TX1, reg_wr)) begin
                    tx_new_reg[c] <= 1'b1;
                end
                if (hit(reg_addr, (c == 0) ? REG_MON_RX0 : REG_MON_RX1, reg_rd)) begin
                    byte_new_reg[c] <= 1'b0;
                    if (byte_new_reg[c] && rx_handshake_ctrl[c] && !mr_out_reg[c]) begin
                        ack_req_reg[c] <= 1'b1; // RQ18
                    end
                end
                if (frame_done_reg && ch_en[c]) begin
                    prev_mx_reg[c] <= rmx[c];
                    prev_mr_reg[c] <= rmr[c];
                    // Receiver side.
                    if (prev_mx_reg[c] && !rmx[c]) begin
                        mor_reg[c] <= rmon[c]; // RQ15
                        hsstat_reg[4*c+HS_DR] <= 1'b1; // RQ15
                        byte_new_reg[c] <= 1'b1;
                        rx_act_reg[c] <= 1'b1;
                    end
                    if (rmx[c] && prev_mx_reg[c] && rx_act_reg[c]) begin
                        hsstat_reg[4*c+HS_ER] <= 1'b1; // RQ20
                        rx_act_reg[c] <= 1'b0;
                    end
                    if (!rx_handshake_ctrl[c]) begin
                        mr_out_reg[c] <= 1'b1; // RQ21 RQ22
                        ack_req_reg[c] <= 1'b0;
                    end else if (ack_req_reg[c] && !mr_out_reg[c]) begin
                        mr_out_reg[c] <= 1'b1; // RQ18
                        ack_req_reg[c] <= 1'b0;
                    end else begin
                        mr_out_reg[c] <= 1'b0; // RQ16
                    end
                    // Transmitter side.
                    if (mac_reg[c] && prev_mr_reg[c] && !rmr[c]) begin
                        hsstat_reg[4*c+HS_DA] <= 1'b1; // RQ16 RQ18
                    end
                    if (mac_reg[c] && !rmr[c]) mr_seen_reg[c] <= 1'b1;
                    if (tx_handshake_ctrl[c] && mr_seen_reg[c] && rmr[c] && prev_mr_reg[c]) begin
                        hsstat_reg[4*c+HS_AB] <= 1'b1; // RQ22
                        mr_seen_reg[c] <= 1'b0;
                    end
                    if (tx_handshake_ctrl[c]) begin
                        mac_reg[c] <= 1'b1; // RQ13
                    end else if (rmr[c] && prev_mr_reg[c]) begin
                        mac_reg[c] <= 1'b0; // RQ21
                        mr_seen_reg[c] <= 1'b0;
                    end
                    if (!tx_handshake_ctrl[c]) begin
                        mx_out_reg[c] <= 1'b1; // RQ20
                    end else if (tx_new_reg[c] && !mx_out_reg[c]) begin
                        mx_out_reg[c] <= 1'b1; // RQ17
                        tx_new_reg[c] <= 1'b0;
                    end else begin
                        mx_out_reg[c] <= 1'b0; // RQ14 RQ11
                        if (mx_out_reg[c]) tx_new_reg[c] <= 1'b0;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Outgoing frame
    // ****************************************************************
    // The byte repeats every frame; only the handshake bits announce news.
    always_comb begin
        tx_frame.spare = 1'b1;
        tx_frame.access = 1'b1;
        tx_frame.ci0 = grant_reg ? cmd_ind_tx_reg0_reg : CI0_RESET; // RQ3 RQ4
        tx_frame.ci1 = ch_en[1] ? cmd_ind_tx_reg1_reg : CI1_RESET; // RQ5
        tx_frame.mon0 = mox_reg[0]; // RQ11
        tx_frame.mon1 = ch_en[1] ? mox_reg[1] : MON_RESET; // RQ10
        tx_frame.mr0 = !(ch_en[0] && rx_handshake_ctrl[0]) || mr_out_reg[0]; // RQ12
        tx_frame.mx0 = !(ch_en[0] && tx_handshake_ctrl[0]) || mx_out_reg[0]; // RQ12
        tx_frame.mr1 = !(ch_en[1] && rx_handshake_ctrl[1]) || mr_out_reg[1]; // RQ12
        tx_frame.mx1 = !(ch_en[1] && tx_handshake_ctrl[1]) || mx_out_reg[1]; // RQ12
    end
    assign tx_word = 32'(tx_frame);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_ci0_dll;
        frame_done_reg && rx_frame.ci0 == ci0_prev_reg && rx_frame.ci0 != cmd_ind_rx_reg0_reg
            |=> cmd_ind_rx_reg0_reg == $past(rx_frame.ci0) && evt_reg[EV_CI0];
    endproperty
    a_ci0_dll: assert property (p_ci0_dll) else $error("code0 not accepted"); // RQ2

    property p_ci0_single;
        frame_done_reg && rx_frame.ci0 != ci0_prev_reg |=> $stable(cmd_ind_rx_reg0_reg);
    endproperty
    a_ci0_single: assert property (p_ci0_single) else $error("code0 taken early"); // RQ2

    property p_ci1_now;
        frame_done_reg && ch_en[1] && rx_frame.ci1 != cmd_ind_rx_reg1_reg
            |=> cmd_ind_rx_reg1_reg == $past(rx_frame.ci1) && evt_reg[EV_CI1];
    endproperty
    a_ci1_now: assert property (p_ci1_now) else $error("code1 change missed"); // RQ6

    property p_old_latch;
        frame_done_reg && !newer && !prev_e_reg
            |=> mor_reg[0] == $past(rx_frame.mon0) && evt_reg[EV_MON];
    endproperty
    a_old_latch: assert property (p_old_latch) else $error("old monitor latch"); // RQ9

    property p_store;
        frame_done_reg && newer && prev_mx_reg[0] && !rx_frame.mx0
            |=> mor_reg[0] == $past(rx_frame.mon0) && hsstat_reg[HS_DR];
    endproperty
    a_store: assert property (p_store) else $error("monitor byte not stored"); // RQ15

    property p_new_byte;
        frame_done_reg && newer && tx_handshake_ctrl[0] && tx_new_reg[0] && !mx_out_reg[0]
            |=> mx_out_reg[0] ##1 (!frame_done_reg)[*1];
    endproperty
    a_new_byte: assert property (p_new_byte) else $error("no inactive frame"); // RQ17

    property p_mac_fall;
        $fell(mac_reg[0]) |-> !$past(tx_handshake_ctrl[0]);
    endproperty
    a_mac_fall: assert property (p_mac_fall) else $error("busy ended early"); // RQ21

    property p_mx_idle;
        frame_done_reg && !tx_handshake_ctrl[0] |=> mx_out_reg[0] && tx_frame.mx0;
    endproperty
    a_mx_idle: assert property (p_mx_idle) else $error("handshake not idle"); // RQ12

    property p_ack_flag;
        frame_done_reg && newer && mac_reg[0] && prev_mr_reg[0] && !rx_frame.mr0
            |=> hsstat_reg[HS_DA];
    endproperty
    a_ack_flag: assert property (p_ack_flag) else $error("ack status missed"); // RQ16

    property p_abort_flag;
        frame_done_reg && newer && tx_handshake_ctrl[0] && mr_seen_reg[0] && rx_frame.mr0 && prev_mr_reg[0]
            |=> hsstat_reg[HS_AB];
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("abort status missed"); // RQ22

    property p_general_status_register;
        reg_rd && reg_addr == REG_GEN_STAT |=> reg_rdata[1:0] == $past(mac_reg);
    endproperty
    a_general_status_register: assert property (p_general_status_register) else $error("busy read wrong"); // RQ13
endmodule
`default_nettype wire

/* File: rtl/sbc_pkg.sv */
/*
 * Shared constants and carrier types for the frame bus side-channel block.
 * Assumes a 32-bit frame per direction, bit 0 sent first after frame sync.
 */
package sbc_pkg;
    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int FRAME_BITS = 32;
    localparam logic [4:0] FRAME_LAST = 5'h1F;
    typedef struct packed {
        logic spare;
        logic access;
        logic mx1;
        logic mr1;
        logic mx0;
        logic mr0;
        logic [5:0] ci1;
        logic [3:0] ci0;
        logic [7:0] mon1;
        logic [7:0] mon0;
    } sbc_frame_t;

    // ****************************************************************
    // Register map (word index on the plain register port)
    // ****************************************************************
    localparam logic [3:0] REG_CI_RX0 = 4'h0;
    localparam logic [3:0] REG_CI_TX0 = 4'h1;
    localparam logic [3:0] REG_CI_RX1 = 4'h2;
    localparam logic [3:0] REG_CI_TX1 = 4'h3;
    localparam logic [3:0] REG_MON_RX0 = 4'h4;
    localparam logic [3:0] REG_MON_TX0 = 4'h5;
    localparam logic [3:0] REG_MON_RX1 = 4'h6;
    localparam logic [3:0] REG_MON_TX1 = 4'h7;
    localparam logic [3:0] REG_HS_CTRL = 4'h8;
    localparam logic [3:0] REG_HS_STAT = 4'h9;
    localparam logic [3:0] REG_GEN_STAT = 4'hA;
    localparam logic [3:0] REG_EXT_IRQ = 4'hB;
    localparam logic [3:0] REG_MODE = 4'hC;

    // Handshake control: mrc at 2*ch, mxc at 2*ch+1.
    // Handshake status: per channel 4 bits starting at 4*ch.
    localparam int HS_DR = 0;
    localparam int HS_ER = 1;
    localparam int HS_DA = 2;
    localparam int HS_AB = 3;
    // Extended event register bits.
    localparam int EV_CI0 = 0;
    localparam int EV_CI1 = 1;
    localparam int EV_MON = 2;
    // Mode register bits.
    localparam int MODE_NEW = 0;
    localparam int MODE_TERM = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [3:0] CI0_RESET = 4'hF;
    localparam logic [5:0] CI1_RESET = 6'h3F;
    localparam logic [7:0] MON_RESET = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

/* File: dv/sbc_far_peer.sv */
/*
 * Far-side model of the frame bus: bit clock, frame sync, the incoming
 * frame word, and capture of the frame word that the block sends back.
 * Assumes the bench changes the word to send only after frame sync rises.
 */
`timescale 1ns/1ns
`default_nettype none
module sbc_far_peer
    import sbc_pkg::*;
(
    output logic link_clk,
    output logic frame_sync,
    output logic link_rx,
    input wire logic link_tx,
    input wire sbc_frame_t to_dev,
    output sbc_frame_t from_dev
);
    // ****************************************************************
    // Frame engine
    // ****************************************************************
    // The word is taken once as sync rises, so a change made by the bench
    // right after sync lands whole in the next frame, never torn.
    sbc_frame_t word;
    sbc_frame_t shift;
    initial begin
        link_clk = 1'b0;
        frame_sync = 1'b0;
        link_rx = 1'b1;
        from_dev = '1;
        shift = '1;
        word = '1;
        forever begin
            for (int i = 0; i < FRAME_BITS; i++) begin
                if (i == 0) begin
                    from_dev = shift;
                    word = to_dev;
                end
                link_rx = word[i];
                frame_sync = (i == 0);
                #62;
                link_clk = 1'b1;
                #63;
                link_clk = 1'b0;
                shift[i] = link_tx;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/serial_bus_cmd_monitor_channels_test.sv */
/*
 * Self-checking bench for the frame bus side channels: register port
 * tasks, far-side frame model and the scenario sequence.
 * Assumes the package register map and frame bit layout.
 */
`timescale 1ns/1ns
`default_nettype none
module serial_bus_cmd_monitor_channels_test
    import sbc_pkg::*;
;
    logic clk;
    logic rstn;
    logic link_clk;
    logic frame_sync;
    logic link_rx;
    logic link_tx;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    sbc_frame_t far_tx;
    sbc_frame_t far_rx;
    logic [7:0] v;
    logic [7:0] cnt;
    int err_count;
    int num_checks;

    sbc_side_channels dut (.clk(clk), .rstn(rstn), .link_clk(link_clk),
        .frame_sync(frame_sync), .link_rx(link_rx), .link_tx(link_tx),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sbc_far_peer peer (.link_clk(link_clk), .frame_sync(frame_sync),
        .link_rx(link_rx), .link_tx(link_tx), .to_dev(far_tx), .from_dev(far_rx));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rc(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(name, d, exp);
    endtask
    // Frame-sync edges are the bench's unit of time on the link side.
    task automatic frm(input int k);
        repeat (k) @(posedge frame_sync);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #600000;
        err_count++;
        $display("BAD watchdog expected done seen hang");
        end_of_test();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        far_tx = '1;
        err_count = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rc("ci_rx0", REG_CI_RX0, 8'h0F);
        rc("ci_rx1", REG_CI_RX1, 8'h3F);
        rc("mon_rx0", REG_MON_RX0, 8'hFF);
        rc("hs_ctrl", REG_HS_CTRL, 8'h00);
        rc("gen_stat", REG_GEN_STAT, 8'h00);
        wr(4'hD, 8'h5A);
        rc("unmapped", 4'hD, 8'h00);
        @(posedge clk);
        #1;
        chk("rdata_idle", reg_rdata, 8'h00);
        $display("test reset_and_map done");

        wr(REG_CI_TX0, 8'h0A);
        frm(3);
        chk("ci0_tx", {4'h0, far_rx.ci0}, 8'h0A);
        frm(1);
        chk("ci0_repeat", {4'h0, far_rx.ci0}, 8'h0A);
        far_tx.access = 1'b0;
        frm(3);
        chk("ci0_no_grant", {4'h0, far_rx.ci0}, 8'h0F);
        far_tx.access = 1'b1;
        far_tx.ci0 = 4'h3;
        frm(1);
        far_tx.ci0 = 4'hF;
        frm(3);
        rc("ci0_glitch", REG_EXT_IRQ, 8'h00);
        rc("ci0_keep", REG_CI_RX0, 8'h0F);
        far_tx.ci0 = 4'h3;
        frm(4);
        rc("ci0_event", REG_EXT_IRQ, 8'h01);
        rc("ci0_code", REG_CI_RX0, 8'h03);
        $display("test code_channel0 done");

        wr(REG_MODE, 8'h03);
        wr(REG_CI_TX1, 8'h2A);
        far_tx.ci1 = 6'h15;
        frm(2);
        rc("ci1_event", REG_EXT_IRQ, 8'h02);
        rc("ci1_code", REG_CI_RX1, 8'h15);
        frm(1);
        chk("ci1_tx", {2'h0, far_rx.ci1}, 8'h2A);
        wr(REG_MODE, 8'h01);
        far_tx.ci1 = 6'h2A;
        frm(3);
        rc("ci1_off", REG_EXT_IRQ, 8'h00);
        $display("test code_channel1 done");

        wr(REG_MODE, 8'h00);
        wr(REG_MON_TX0, 8'h5A);
        far_tx.mx0 = 1'b0;
        frm(1);
        far_tx.mx0 = 1'b1;
        far_tx.mon0 = 8'h3C;
        frm(1);
        far_tx.mon0 = 8'hFF;
        frm(2);
        chk("old_tx", far_rx.mon0, 8'h5A);
        rc("old_rx", REG_MON_RX0, 8'h3C);
        rc("old_event", REG_EXT_IRQ, 8'h04);
        $display("test old_monitor done");

        wr(REG_MODE, 8'h01);
        frm(2);
        chk("mx_idle", {7'h0, far_rx.mx0}, 8'h01);
        chk("mr_idle", {7'h0, far_rx.mr0}, 8'h01);
        rc("busy_before", REG_GEN_STAT, 8'h00);
        wr(REG_MON_TX0, 8'h12);
        wr(REG_HS_CTRL, 8'h0A);
        frm(3);
        chk("mx_active", {7'h0, far_rx.mx0}, 8'h00);
        chk("mx1_absent", {7'h0, far_rx.mx1}, 8'h01);
        frm(4);
        chk("byte_repeat", far_rx.mon0, 8'h12);
        rd(REG_GEN_STAT, v);
        chk("busy_set", {7'h0, v[0]}, 8'h01);
        far_tx.mr0 = 1'b0;
        frm(3);
        rc("ack_first", REG_HS_STAT, 8'h04);
        wr(REG_MON_TX0, 8'h34);
        cnt = 8'h00;
        repeat (4) begin
            frm(1);
            cnt = cnt + {7'h0, far_rx.mx0};
        end
        chk("mx_gap", cnt, 8'h01);
        chk("next_byte", far_rx.mon0, 8'h34);
        far_tx.mr0 = 1'b1;
        frm(1);
        far_tx.mr0 = 1'b0;
        frm(3);
        rc("ack_next", REG_HS_STAT, 8'h04);
        far_tx.mr0 = 1'b1;
        frm(4);
        rc("abort", REG_HS_STAT, 8'h08);
        wr(REG_HS_CTRL, 8'h00);
        frm(4);
        chk("mx_forced", {7'h0, far_rx.mx0}, 8'h01);
        rc("busy_clear", REG_GEN_STAT, 8'h00);
        $display("test monitor_transmit done");

        far_tx.mon0 = 8'h77;
        far_tx.mx0 = 1'b0;
        frm(3);
        rc("rx_first", REG_HS_STAT, 8'h01);
        rc("rx_byte", REG_MON_RX0, 8'h77);
        wr(REG_HS_CTRL, 8'h01);
        frm(3);
        chk("mr_ack", {7'h0, far_rx.mr0}, 8'h00);
        far_tx.mx0 = 1'b1;
        far_tx.mon0 = 8'h66;
        frm(1);
        far_tx.mx0 = 1'b0;
        frm(3);
        rc("rx_next", REG_HS_STAT, 8'h01);
        rc("rx_byte2", REG_MON_RX0, 8'h66);
        cnt = 8'h00;
        repeat (4) begin
            frm(1);
            cnt = cnt + {7'h0, far_rx.mr0};
        end
        chk("mr_gap", cnt, 8'h01);
        far_tx.mx0 = 1'b1;
        frm(4);
        rc("rx_end", REG_HS_STAT, 8'h02);
        wr(REG_HS_CTRL, 8'h00);
        frm(3);
        chk("mr_forced", {7'h0, far_rx.mr0}, 8'h01);
        wr(REG_MODE, 8'h03);
        wr(REG_HS_CTRL, 8'h08);
        frm(3);
        chk("mx1_active", {7'h0, far_rx.mx1}, 8'h00);
        rc("busy1", REG_GEN_STAT, 8'h02);
        $display("test monitor_receive done");
        end_of_test();
    end
endmodule
`default_nettype wire
